// File: sdt_timing_regs.svh
/*
  Timing constants for the command-timing pair (device end and controller
  end). Assumes a single 125 MHz command clock; times are in ps except the refresh periods (ms) and the cycle counts.
*/
`ifndef SDT_TIMING_REGS_SVH
`define SDT_TIMING_REGS_SVH

// ============================================================
// clock and conversion
`define SDT_CLK_PS 8000
`define SDT_CK_UP(ps) (((ps) + `SDT_CLK_PS - 1) / `SDT_CLK_PS)
`define SDT_CK_DN(ps) ((ps) / `SDT_CLK_PS)

// ============================================================
// refresh
`define SDT_REF_MS 64
`define SDT_REF_HOT_MS 32
`define SDT_REF_ROWS 8192
`define SDT_REFI_PS(ms) (((ms) * 64'd1000000000) / `SDT_REF_ROWS)
`define SDT_REF_WIN_PS 70300000
`define SDT_REF_WIN_CNT 9
`define SDT_MAX_POSTPONE 8
`define SDT_SLOW_CLK_PS 40000
`define SDT_REFPDEN_CK 2

// ============================================================
// write recovery and loop exit
`define SDT_WR_OFF_PS 15000
`define SDT_WR_OFF_CK 4
`define SDT_WR_START_LONG 4
`define SDT_WR_START_FIX 2
`define SDT_LOOP_EXIT_CK 10

`endif

// File: sdt_pkg.sv
/*
  Types shared by both ends of the command link.
  Assumes the timing header supplies every number.
*/
package sdt_pkg;

  // ============================================================
  // command bus encoding
  typedef enum logic [3:0] {
    CMD_NOP,
    CMD_ACTIVATE,
    CMD_READ,
    CMD_READ_AP,
    CMD_WRITE,
    CMD_WRITE_AP,
    CMD_PRECHARGE,
    CMD_PRECHARGE_ALL,
    CMD_REFRESH,
    CMD_MODE_SET
  } sdt_cmd_e;

  // ============================================================
  // controller sequencer
  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_RCD,
    ST_PREA,
    ST_RP,
    ST_RFC,
    ST_PDE,
    ST_PD
  } sdt_state_e;

endpackage

// File: sdt_if.sv
/*
  Command link between the controller end and the device end.
  Assumes both ends run on the same clock; no clocking block.
*/
`timescale 1ns/1ps

interface sdt_if
  import sdt_pkg::*;
#(
  parameter int NB = 8
);
  logic                  cke;
  logic                  mem_reset_b;
  sdt_cmd_e              cmd;
  logic [$clog2(NB)-1:0] bank;
  logic                  chop_otf;
  logic                  strobe_win;

  modport ctrl (
    output cke,
    output mem_reset_b,
    output cmd,
    output bank,
    output chop_otf,
    input  strobe_win
  );

  modport dev (
    input  cke,
    input  mem_reset_b,
    input  cmd,
    input  bank,
    input  chop_otf,
    output strobe_win
  );
endinterface

// File: sdt_device.sv
/*
  Device end: checks command spacing, holds off auto precharge, starts
  write recovery and marks the read strobe window.
  Assumes the controller drives the link from the same clock.
*/
`timescale 1ns/1ps
`include "sdt_timing_regs.svh"

module sdt_device
  import sdt_pkg::*;
#(
  parameter int NB     = 8,
  parameter int RAS_PS = 35000,
  parameter int RFC_PS = 260000,
  parameter int WR_PS  = 15000
)(
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  sdt_if.dev                         link,
  input  wire logic [3:0]            read_latency_cycles,
  input  wire logic [3:0]            additive_latency_cycles,
  input  wire logic [3:0]            write_latency_cycles,
  input  wire logic                  loop_off,
  input  wire logic                  chop_fixed,
  output logic      [NB-1:0]         bank_open,
  output logic                       internal_pre,
  output logic                       strobe_window_start,
  output logic      [15:0]           refresh_count,
  output logic                       timing_error
);

  // ============================================================
  // cycle counts
  localparam logic [15:0] RAS_CK = 16'(`SDT_CK_UP(RAS_PS));
  localparam logic [15:0] RFC_CK = 16'(`SDT_CK_UP(RFC_PS));
  localparam logic [15:0] WR_CK  = 16'(`SDT_CK_UP(WR_PS));
  localparam logic [15:0] WR_OFF_UP = 16'(`SDT_CK_UP(`SDT_WR_OFF_PS));
  localparam logic [15:0] WR_OFF_CK = (WR_OFF_UP > 16'(`SDT_WR_OFF_CK)) ?
                                      WR_OFF_UP : 16'(`SDT_WR_OFF_CK);

  sdt_cmd_e    cmd_v;
  logic [15:0] ras_cnt [NB];
  logic [15:0] wr_cnt  [NB];
  logic [NB-1:0] ap_pend;
  logic [15:0] rd_cnt;
  logic [15:0] rfc_cnt;
  logic [15:0] wr_len;
  logic [15:0] rd_len;

  // commands only count while out of reset with clock enable high
  assign cmd_v = (link.mem_reset_b && link.cke) ? link.cmd : CMD_NOP;

  assign wr_len = 16'(write_latency_cycles) +
                  (chop_fixed ? 16'(`SDT_WR_START_FIX) :
                   16'(`SDT_WR_START_LONG)) +
                  (loop_off ? WR_OFF_CK : WR_CK);
  assign rd_len = 16'(read_latency_cycles) +
                  16'(additive_latency_cycles) -
                  (loop_off ? 16'h0001 : 16'h0000);

  assign link.strobe_win = strobe_window_start;

  // ============================================================
  // per-bank row state and auto precharge hold-off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_open    <= '0;
      ap_pend      <= '0;
      internal_pre <= 1'b0;
      for (int b = 0; b < NB; b++) begin
        ras_cnt[b] <= 16'h0000;
        wr_cnt[b]  <= 16'h0000;
      end
    end else begin
      internal_pre <= 1'b0;
      for (int b = 0; b < NB; b++) begin
        // counted on real clock edges, one per cycle
        if (ras_cnt[b] != 16'hffff)
          ras_cnt[b] <= ras_cnt[b] + 16'h0001;
        if (wr_cnt[b] != 16'h0000)
          wr_cnt[b] <= wr_cnt[b] - 16'h0001;
        if (ap_pend[b] && ras_cnt[b] >= RAS_CK &&
            wr_cnt[b] == 16'h0000) begin
          ap_pend[b]   <= 1'b0;
          bank_open[b] <= 1'b0;
          internal_pre <= 1'b1;
        end
      end
      case (cmd_v)
        CMD_ACTIVATE: begin
          bank_open[link.bank] <= 1'b1;
          ras_cnt[link.bank]   <= 16'h0000;
        end
        CMD_READ_AP:
          ap_pend[link.bank] <= 1'b1;
        CMD_WRITE:
          wr_cnt[link.bank] <= wr_len;
        CMD_WRITE_AP: begin
          wr_cnt[link.bank]  <= wr_len;
          ap_pend[link.bank] <= 1'b1;
        end
        CMD_PRECHARGE:
          bank_open[link.bank] <= 1'b0;
        CMD_PRECHARGE_ALL:
          bank_open <= '0;
        default: ;
      endcase
    end
  end

  // ============================================================
  // read strobe window; a later read restarts the count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_cnt              <= 16'h0000;
      strobe_window_start <= 1'b0;
    end else begin
      strobe_window_start <= (rd_cnt == 16'h0001);
      if (cmd_v == CMD_READ || cmd_v == CMD_READ_AP)
        rd_cnt <= rd_len;
      else if (rd_cnt != 16'h0000)
        rd_cnt <= rd_cnt - 16'h0001;
    end
  end

  // ============================================================
  // refresh acceptance and spacing check
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rfc_cnt       <= 16'h0000;
      refresh_count <= 16'h0000;
      timing_error  <= 1'b0;
    end else begin
      if (rfc_cnt != 16'h0000)
        rfc_cnt <= rfc_cnt - 16'h0001;
      // spacing of exactly the rounded-up count is legal
      if (cmd_v != CMD_NOP && rfc_cnt != 16'h0000)
        timing_error <= 1'b1;
      if (cmd_v == CMD_ACTIVATE && bank_open[link.bank])
        timing_error <= 1'b1;
      if (cmd_v == CMD_REFRESH) begin
        // back-to-back refresh bursts carry no limit of their own
        rfc_cnt       <= RFC_CK - 16'h0001;
        refresh_count <= refresh_count + 16'h0001;
      end
    end
  end

endmodule

// File: sdt_controller.sv
/*
  Controller end: sequences activate, read/write, precharge, refresh
  and power-down on the command link, keeping the device's timing.
  Assumes one clock shared with the device end and a user port that
  holds a request until it is taken.
*/
`timescale 1ns/1ps
`include "sdt_timing_regs.svh"

module sdt_controller
  import sdt_pkg::*;
#(
  parameter int NB           = 8,
  parameter int RAS_PS       = 35000,
  parameter int RFC_PS       = 260000,
  parameter int RP_PS        = 13750,
  parameter int RCD_PS       = 13750,
  parameter int WR_PS        = 15000,
  parameter int LOOP_EXIT_PS = 24000,
  parameter int RST_HOLD_CK  = 16,
  parameter int REF_WIN_CK   = `SDT_CK_DN(`SDT_REF_WIN_PS)
)(
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  sdt_if.ctrl                        link,
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic [$clog2(NB)-1:0] req_bank,
  input  wire logic                  req_chop,
  input  wire logic                  req_autopre,
  output logic                       req_ready,
  input  wire logic [3:0]            write_latency_cycles,
  input  wire logic                  chop_fixed,
  input  wire logic                  loop_off,
  input  wire logic                  latency_change,
  input  wire logic                  hot,
  input  wire logic                  pd_req,
  output logic                       in_powerdown,
  output logic      [3:0]            refresh_debt
);

  // ============================================================
  // cycle counts
  localparam logic [15:0] RAS_CK = 16'(`SDT_CK_UP(RAS_PS));
  localparam logic [15:0] RFC_CK = 16'(`SDT_CK_UP(RFC_PS));
  localparam logic [15:0] RP_CK  = 16'(`SDT_CK_UP(RP_PS));
  localparam logic [15:0] RCD_CK = 16'(`SDT_CK_UP(RCD_PS));
  localparam logic [15:0] WR_CK  = 16'(`SDT_CK_UP(WR_PS));
  localparam logic [15:0] WR_OFF_UP = 16'(`SDT_CK_UP(`SDT_WR_OFF_PS));
  localparam logic [15:0] WR_OFF_CK = (WR_OFF_UP > 16'(`SDT_WR_OFF_CK)) ?
                                      WR_OFF_UP : 16'(`SDT_WR_OFF_CK);
  localparam logic [15:0] LX_UP  = 16'(`SDT_CK_UP(LOOP_EXIT_PS));
  localparam logic [15:0] LX_CK  = (LX_UP > 16'(`SDT_LOOP_EXIT_CK)) ?
                                   LX_UP : 16'(`SDT_LOOP_EXIT_CK);
  localparam logic [15:0] REFI_CK =
    16'(`SDT_CK_DN(`SDT_REFI_PS(`SDT_REF_MS)));
  localparam logic [15:0] REFI_HOT_CK =
    16'(`SDT_CK_DN(`SDT_REFI_PS(`SDT_REF_HOT_MS)));
  localparam logic [15:0] WIN_CK = 16'(REF_WIN_CK);
  localparam logic [15:0] SLOT_CK = RFC_CK + RP_CK + 16'h0002;
  localparam logic SLOW_CLK = (`SDT_CLK_PS > `SDT_SLOW_CLK_PS);

  sdt_state_e  state;
  logic [15:0] wait_cnt;
  logic        rstb_reg;
  logic        cke_reg;
  sdt_cmd_e    cmd_reg;
  logic [$clog2(NB)-1:0] bank_reg;
  logic        chop_reg;
  logic        pend_write;
  logic        pend_ap;
  logic [NB-1:0] open;
  logic [NB-1:0] ap_pend;
  logic [15:0] ras_cnt [NB];
  logic [15:0] wr_cnt  [NB];
  logic [15:0] refi_cnt;
  logic [15:0] win_cnt;
  logic [3:0]  ref_in_win;
  logic [15:0] exit_cnt;
  logic [15:0] pd_gap;
  logic        gate_ok;
  logic        any_open;
  logic        win_force;
  logic        ref_due;
  logic        take;
  logic        pd_exit;
  logic        ref_issued;
  logic [15:0] wr_len;
  logic [15:0] need;

  assign link.cke         = cke_reg;
  assign link.mem_reset_b = rstb_reg;
  assign link.cmd         = cmd_reg;
  assign link.bank        = bank_reg;
  assign link.chop_otf    = chop_reg;

  assign ref_issued = (cmd_reg == CMD_REFRESH);
  assign wr_len = 16'(write_latency_cycles) +
                  (chop_fixed ? 16'(`SDT_WR_START_FIX) :
                   16'(`SDT_WR_START_LONG)) +
                  (loop_off ? WR_OFF_CK : WR_CK);
  assign need = 16'(`SDT_REF_WIN_CNT) - {12'h000, ref_in_win};
  assign win_force = (ref_in_win < 4'(`SDT_REF_WIN_CNT)) &&
                     ((WIN_CK - win_cnt) <= 16'(need * SLOT_CK));
  assign ref_due = win_force ||
                   (refresh_debt >= 4'(`SDT_MAX_POSTPONE)) ||
                   (refresh_debt != 4'h0 && !req_valid);
  assign take = (state == ST_IDLE) && req_valid && req_ready &&
                !latency_change;
  // a due window refresh must wake the part as well
  assign pd_exit = (state == ST_PD) &&
                   (!pd_req || refresh_debt != 4'h0 || win_force);

  always_comb begin
    gate_ok  = 1'b1;
    any_open = 1'b0;
    for (int b = 0; b < NB; b++) begin
      any_open = any_open | open[b];
      if (wr_cnt[b] != 16'h0000 || (open[b] && ras_cnt[b] < RAS_CK))
        gate_ok = 1'b0;
    end
  end

  // ============================================================
  // sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= ST_RESET;
      wait_cnt   <= 16'(RST_HOLD_CK);
      rstb_reg   <= 1'b0;
      cke_reg    <= 1'b0;
      in_powerdown <= 1'b1;
      cmd_reg    <= CMD_NOP;
      bank_reg   <= '0;
      chop_reg   <= 1'b0;
      pend_write <= 1'b0;
      pend_ap    <= 1'b0;
      req_ready  <= 1'b0;
    end else begin
      cmd_reg   <= CMD_NOP;
      req_ready <= (state == ST_IDLE) && !take && !ref_due && !pd_req &&
                   exit_cnt <= 16'h0001 && !latency_change;
      if (wait_cnt != 16'h0000)
        wait_cnt <= wait_cnt - 16'h0001;
      case (state)
        ST_RESET: if (wait_cnt == 16'h0000) begin
          rstb_reg <= 1'b1;
          cke_reg  <= 1'b1;
          in_powerdown <= 1'b0;
          state    <= ST_IDLE;
        end
        ST_IDLE: if (take) begin
          bank_reg   <= req_bank;
          chop_reg   <= req_chop;
          pend_write <= req_write;
          pend_ap    <= req_autopre;
          if (open[req_bank]) begin
            cmd_reg <= req_write ?
                       (req_autopre ? CMD_WRITE_AP : CMD_WRITE) :
                       (req_autopre ? CMD_READ_AP : CMD_READ);
          end else begin
            cmd_reg  <= CMD_ACTIVATE;
            wait_cnt <= RCD_CK - 16'h0001;
            state    <= ST_RCD;
          end
        end else if (ref_due) begin
          if (any_open) begin
            state <= ST_PREA;
          end else begin
            cmd_reg  <= CMD_REFRESH;
            wait_cnt <= RFC_CK;
            state    <= ST_RFC;
          end
        end else if (pd_req) begin
          state <= any_open ? ST_PREA : ST_PDE;
        end
        ST_RCD: if (wait_cnt == 16'h0000) begin
          cmd_reg <= pend_write ?
                     (pend_ap ? CMD_WRITE_AP : CMD_WRITE) :
                     (pend_ap ? CMD_READ_AP : CMD_READ);
          state   <= ST_IDLE;
        end
        ST_PREA: if (gate_ok) begin
          cmd_reg  <= CMD_PRECHARGE_ALL;
          wait_cnt <= RP_CK - 16'h0001;
          state    <= ST_RP;
        end
        ST_RP: if (wait_cnt == 16'h0000)
          state <= ST_IDLE;
        // wait_cnt starts at the full count, so one NOP always follows
        ST_RFC: if (wait_cnt == 16'h0000) begin
          if (SLOW_CLK) begin
            cmd_reg  <= CMD_PRECHARGE_ALL;
            wait_cnt <= RP_CK - 16'h0001;
            state    <= ST_RP;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_PDE: if (ref_due || !pd_req) begin
          state <= ST_IDLE;
        end else if (pd_gap == 16'h0000 && gate_ok) begin
          cke_reg <= 1'b0;
          in_powerdown <= 1'b1;
          state   <= ST_PD;
        end
        ST_PD: if (pd_exit) begin
          cke_reg <= 1'b1;
          in_powerdown <= 1'b0;
          state   <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ============================================================
  // bank tracking, mirrors the device's auto precharge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      open    <= '0;
      ap_pend <= '0;
      for (int b = 0; b < NB; b++) begin
        ras_cnt[b] <= 16'h0000;
        wr_cnt[b]  <= 16'h0000;
      end
    end else begin
      for (int b = 0; b < NB; b++) begin
        if (ras_cnt[b] != 16'hffff)
          ras_cnt[b] <= ras_cnt[b] + 16'h0001;
        if (wr_cnt[b] != 16'h0000)
          wr_cnt[b] <= wr_cnt[b] - 16'h0001;
        if (ap_pend[b] && ras_cnt[b] >= RAS_CK &&
            wr_cnt[b] == 16'h0000) begin
          ap_pend[b] <= 1'b0;
          open[b]    <= 1'b0;
        end
      end
      case (cmd_reg)
        CMD_ACTIVATE: begin
          open[bank_reg]    <= 1'b1;
          ras_cnt[bank_reg] <= 16'h0000;
        end
        CMD_READ_AP:
          ap_pend[bank_reg] <= 1'b1;
        CMD_WRITE:
          wr_cnt[bank_reg] <= wr_len;
        CMD_WRITE_AP: begin
          wr_cnt[bank_reg]  <= wr_len;
          ap_pend[bank_reg] <= 1'b1;
        end
        CMD_PRECHARGE_ALL:
          open <= '0;
        default: ;
      endcase
    end
  end

  // ============================================================
  // refresh debt and fixed window, restarted every WIN_CK cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      refi_cnt     <= 16'h0000;
      refresh_debt <= 4'h0;
      win_cnt      <= 16'h0000;
      ref_in_win   <= 4'h0;
    end else begin
      // a hot part needs twice the rate
      if (refi_cnt >= (hot ? REFI_HOT_CK : REFI_CK) - 16'h0001) begin
        refi_cnt <= 16'h0000;
        if (!ref_issued && refresh_debt != 4'hf)
          refresh_debt <= refresh_debt + 4'h1;
      end else begin
        refi_cnt <= refi_cnt + 16'h0001;
        if (ref_issued && refresh_debt != 4'h0)
          refresh_debt <= refresh_debt - 4'h1;
      end
      if (win_cnt >= WIN_CK - 16'h0001) begin
        win_cnt    <= 16'h0000;
        ref_in_win <= 4'h0;
      end else begin
        win_cnt <= win_cnt + 16'h0001;
        if (ref_issued && ref_in_win != 4'hf)
          ref_in_win <= ref_in_win + 4'h1;
      end
    end
  end

  // ============================================================
  // loop exit and refresh-to-power-down timers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exit_cnt <= 16'h0000;
      pd_gap   <= 16'h0000;
    end else begin
      if (latency_change)
        exit_cnt <= LX_CK;
      else if (pd_exit && loop_off)
        exit_cnt <= LX_CK;
      else if (exit_cnt != 16'h0000)
        exit_cnt <= exit_cnt - 16'h0001;
      // with the loop off the gap also covers the loop exit time
      if (ref_issued)
        pd_gap <= loop_off ? LX_CK :
                  16'(`SDT_REFPDEN_CK);
      else if (pd_gap != 16'h0000)
        pd_gap <= pd_gap - 16'h0001;
    end
  end

endmodule

// File: sdt_link_assertions.sv
/*
  Checker on the command link between controller end and device end.
  Assumes the default parameters and a reset hold of two edges.
*/
`timescale 1ns/1ps

module sdt_link_assertions
  import sdt_pkg::*;
(
  input wire logic     clk,
  input wire logic     rst_b,
  input wire logic     cke,
  input wire logic     mem_reset_b,
  input wire sdt_cmd_e cmd,
  input wire logic     strobe_win
);
  // ============================================================
  // edges since the last refresh and the last activate
  logic [5:0] ref_gap_reg;
  logic [5:0] act_gap_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ref_gap_reg <= 6'h3f;
    else if (cmd == CMD_REFRESH)
      ref_gap_reg <= 6'h00;
    else if (ref_gap_reg != 6'h3f)
      ref_gap_reg <= ref_gap_reg + 6'h01;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      act_gap_reg <= 6'h3f;
    else if (cmd == CMD_ACTIVATE)
      act_gap_reg <= 6'h00;
    else if (act_gap_reg != 6'h3f)
      act_gap_reg <= act_gap_reg + 6'h01;
  end

  // ============================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_access;
    cmd inside {CMD_READ, CMD_READ_AP, CMD_WRITE, CMD_WRITE_AP};
  endsequence
  sequence s_rcd;
    cmd == CMD_NOP ##1 s_access;
  endsequence

  property p_rst_hold;
    $rose(rst_b) |-> !mem_reset_b [*2];
  endproperty
  property p_rst_cke;
    $rose(mem_reset_b) |-> $rose(cke);
  endproperty
  property p_rcd;
    cmd == CMD_ACTIVATE |=> s_rcd;
  endproperty
  property p_ref_nop;
    cmd == CMD_REFRESH |=> cmd == CMD_NOP [*8];
  endproperty
  // saturated counter reads 32 at the 33rd edge after the refresh
  property p_rfc;
    cmd != CMD_NOP |-> ref_gap_reg >= 6'h20;
  endproperty
  property p_pd_gap;
    $fell(cke) |-> ref_gap_reg >= 6'h01;
  endproperty
  property p_pd_nop;
    !cke |-> cmd == CMD_NOP;
  endproperty
  property p_ras;
    cmd == CMD_PRECHARGE_ALL |-> act_gap_reg >= 6'h04;
  endproperty
  property p_strobe;
    cmd inside {CMD_READ, CMD_READ_AP} |-> ##[1:31] strobe_win;
  endproperty

  a_rst_hold: assert property (p_rst_hold)
    else $error("memory reset released early");
  a_rst_cke: assert property (p_rst_cke)
    else $error("clock enable not raised with reset");
  a_rcd: assert property (p_rcd)
    else $error("activate to access spacing");
  a_ref_nop: assert property (p_ref_nop)
    else $error("command right after refresh");
  a_rfc: assert property (p_rfc)
    else $error("refresh cycle time cut short");
  a_pd_gap: assert property (p_pd_gap)
    else $error("power-down too soon after refresh");
  a_pd_nop: assert property (p_pd_nop)
    else $error("command while clock disabled");
  a_ras: assert property (p_ras)
    else $error("precharge before row time");
  a_strobe: assert property (p_strobe)
    else $error("no strobe window after read");
endmodule

// File: sdram_command_timing_rules_tb.sv
/*
  Bench for the controller and device ends, plus a second device fed
  by hand. Assumes the design files and the checker come first.
*/
`timescale 1ns/1ps

module sdram_command_timing_rules_tb
  import sdt_pkg::*;
;
  // ============================================================
  // signals
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        req_valid = 1'b0, req_write = 1'b0, req_chop = 1'b0;
  logic        req_autopre = 1'b0, chop_fixed = 1'b0, loop_off = 1'b0;
  logic        latency_change = 1'b0, hot = 1'b0, pd_req = 1'b0;
  logic [2:0]  req_bank = 3'h0;
  logic [3:0]  read_latency_cycles = 4'h5;
  logic [3:0]  additive_latency_cycles = 4'h0;
  logic [3:0]  write_latency_cycles = 4'h5;
  logic        req_ready, in_powerdown, internal_pre, strobe_window_start;
  logic        timing_error, bad_err, acc;
  logic [3:0]  refresh_debt;
  logic [7:0]  bank_open;
  logic [15:0] refresh_count;
  logic [31:0] seed = 32'h2cd9;
  int          cyc = 0;
  int          err_count = 0;
  int          n_compared = 0;

  sdt_if i_sdt_if ();
  sdt_if i_bad_if ();

  // short window keeps the refresh traffic dense enough to observe
  sdt_controller #(.REF_WIN_CK(400), .RST_HOLD_CK(2)) i_sdt_controller (
    .clk, .rst_b, .link(i_sdt_if.ctrl), .req_valid, .req_write,
    .req_bank, .req_chop, .req_autopre, .req_ready, .write_latency_cycles,
    .chop_fixed, .loop_off, .latency_change, .hot, .pd_req, .in_powerdown,
    .refresh_debt);
  sdt_device i_sdt_device (
    .clk, .rst_b, .link(i_sdt_if.dev), .read_latency_cycles,
    .additive_latency_cycles, .write_latency_cycles, .loop_off,
    .chop_fixed, .bank_open, .internal_pre, .strobe_window_start,
    .refresh_count, .timing_error);
  sdt_device i_bad_device (
    .clk, .rst_b, .link(i_bad_if.dev), .read_latency_cycles,
    .additive_latency_cycles, .write_latency_cycles, .loop_off,
    .chop_fixed, .bank_open(), .internal_pre(), .strobe_window_start(),
    .refresh_count(), .timing_error(bad_err));
  sdt_link_assertions i_sdt_link_assertions (
    .clk, .rst_b, .cke(i_sdt_if.cke), .mem_reset_b(i_sdt_if.mem_reset_b),
    .cmd(i_sdt_if.cmd), .strobe_win(i_sdt_if.strobe_win));

  assign acc = i_sdt_if.cmd inside {CMD_READ, CMD_READ_AP, CMD_WRITE,
                                    CMD_WRITE_AP};

  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ============================================================
  // tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int wr_len();
    return write_latency_cycles + (chop_fixed ? 2 : 4) + (loop_off ? 4 : 2);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wait_hi(ref logic s, output int t);
    int i;
    i = 0;
    // a one-cycle command may already stand when the wait begins
    while (s !== 1'b1 && i < 400) begin
      tick(1);
      i++;
    end
    if (s !== 1'b1) begin
      err_count++;
      conclude();
    end
    t = cyc;
  endtask

  // request stays up until ready is sampled high at an edge
  task automatic request(output int t);
    int i;
    tick(1);
    req_valid = 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (req_ready !== 1'b1 && i < 400);
    if (req_ready !== 1'b1) begin
      err_count++;
      conclude();
    end
    #1;
    req_valid = 1'b0;
    wait_hi(acc, t);
  endtask

  // ============================================================
  // main sequence
  initial begin
    int t0, t1, t2, n0;
    i_bad_if.cke = 1'b1;
    i_bad_if.mem_reset_b = 1'b1;
    i_bad_if.cmd = CMD_NOP;
    i_bad_if.bank = 3'h0;
    i_bad_if.chop_otf = 1'b0;
    tick(5);
    rst_b = 1'b1;
    i_bad_if.cmd = CMD_REFRESH;
    tick(1);
    i_bad_if.cmd = CMD_NOP;
    tick(32);
    i_bad_if.cmd = CMD_REFRESH;
    tick(1);
    chk("spaced refresh", 0, 16'(bad_err));
    tick(1);
    i_bad_if.cmd = CMD_NOP;
    tick(2);
    chk("back to back refresh", 1, 16'(bad_err));
    for (int n = 0; n < 30; n++) begin
      seed = lfsr(seed);
      t2 = 0;
      if (seed[3] || n == 0) begin
        read_latency_cycles = 4'h5 + {1'b0, seed[6:4]};
        additive_latency_cycles = {3'h0, seed[7]};
        write_latency_cycles = 4'h5 + {2'h0, seed[10:9]};
        loop_off = seed[11] || n == 0;
        chop_fixed = seed[12];
        latency_change = 1'b1;
        t2 = cyc;
        tick(1);
        latency_change = 1'b0;
      end
      req_write = seed[13] && n != 0;
      req_autopre = seed[14];
      req_bank = seed[17:15];
      req_chop = seed[18];
      request(t0);
      if (t2 > 0) chk("loop exit wait", 1, 16'(t0 - t2 >= 10));
      if (!req_write) begin
        wait_hi(strobe_window_start, t1);
        chk("strobe delay", 16'(read_latency_cycles + additive_latency_cycles
            + !loop_off), 16'(t1 - t0));
      end else if (req_autopre) begin
        wait_hi(internal_pre, t1);
        chk("recovery", 1, 16'(t1 - t0 >= wr_len()));
        tick(1);
        chk("bank closed", 0, 16'(bank_open[req_bank]));
      end
    end
    loop_off = 1'b1;
    pd_req = 1'b1;
    wait_hi(in_powerdown, t1);
    chk("cke in power-down", 0, 16'(i_sdt_if.cke));
    n0 = in_powerdown;
    pd_req = 1'b0;
    t2 = cyc;
    req_write = 1'b0;
    request(t0);
    if (n0 == 1) chk("exit wait", 1, 16'(t0 - t2 >= 11));
    hot = 1'b1;
    n0 = refresh_count;
    tick(2000);
    chk("refresh count", 1, 16'(refresh_count - n0 >= 36));
    chk("refresh debt", 1, 16'(refresh_debt <= 4'h8));
    chk("device timing error", 0, 16'(timing_error));
    conclude();
  end
endmodule
